// File: hdl/access_control_pkg.sv
// Constants, types and encodings of the CPU-mode access checker
package access_control_pkg;

   localparam int unsigned SEG_COUNT = 64;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned HW_W = 8;
   localparam int unsigned FW_W = 8;
   localparam logic [ADDR_W-1:0] SEG_PTR_RESET = 16'h0000;

   typedef enum logic [2:0] {
      MODE_BOOT = 3'h0,
      MODE_TEST = 3'h1,
      MODE_FIRMWARE = 3'h2,
      MODE_SYSTEM = 3'h3,
      MODE_USER = 3'h4
   } mode_type;

   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_EXEC = 2'h2
   } mem_op_type;

   typedef enum logic [1:0] {
      MASTER_CPU = 2'h0,
      MASTER_COPY = 2'h1,
      MASTER_COPROC = 2'h2
   } master_type;

   typedef enum logic [2:0] {
      REGION_APP_ROM = 3'h0,
      REGION_APP_EEPROM = 3'h1,
      REGION_APP_RAM = 3'h2,
      REGION_FX_RAM = 3'h3,
      REGION_SEC_ROW = 3'h4,
      REGION_OTHER = 3'h5
   } region_type;

   typedef enum logic [2:0] {
      GRP_SEG_CFG = 3'h0,
      GRP_SYS_MGMT = 3'h1,
      GRP_FW_CFG = 3'h2,
      GRP_FW_OS = 3'h3,
      GRP_TEST = 3'h4,
      GRP_HW = 3'h5,
      GRP_CPU_GEN = 3'h6,
      GRP_CPU_BANKED = 3'h7
   } sfr_group_type;

   typedef enum logic [2:0] {
      SPC_NONE = 3'h0,
      SPC_CSR = 3'h1,
      SPC_CLKSEL = 3'h2,
      SPC_PTR_TWO = 3'h3,
      SPC_RANDOM = 3'h4,
      SPC_KEY = 3'h5
   } sfr_special_type;

   typedef struct packed {
      logic [ADDR_W-1:0] first;
      logic [ADDR_W-1:0] last;
      logic rw;
      logic exec;
      logic [HW_W-1:0] hw_rights;
   } seg_entry_type;

endpackage

// File: hdl/cpu_mode_access_control.sv
// CPU-mode access checker for memories and special function registers
`timescale 1ns/100ps
module cpu_mode_access_control
   import access_control_pkg::*;
#(
   parameter int unsigned SEGMENTS = SEG_COUNT
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire mode_type cpu_mode,
   input wire logic called_from_system,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic fetch_from_eeprom,
   input wire logic mem_req,
   input wire master_type mem_master,
   input wire mem_op_type mem_op,
   input wire region_type mem_region,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic sfr_req,
   input wire logic sfr_write,
   input wire sfr_group_type sfr_group,
   input wire sfr_special_type sfr_special,
   input wire logic [$clog2(HW_W)-1:0] sfr_hw_index,
   input wire logic [FW_W-1:0] firewall_ctrl_low,
   input wire logic [FW_W-1:0] firewall_ctrl_high,
   input wire logic [FW_W-1:0] exchange_ram_base_low,
   input wire logic [FW_W-1:0] exchange_ram_base_high,
   input wire logic [FW_W-1:0] exchange_ram_size_low,
   input wire logic [FW_W-1:0] exchange_ram_size_high,
   input wire logic deny_rom_from_eeprom,
   input wire logic copy_deny_rom,
   input wire logic copy_deny_eeprom,
   input wire logic copy_start,
   input wire logic copy_done,
   input wire logic seg_ptr_load,
   input wire logic [ADDR_W-1:0] seg_ptr_value,
   input wire logic seg_load,
   input wire logic [$clog2(SEGMENTS)-1:0] seg_index,
   input wire seg_entry_type seg_entry_in,
   output logic mem_grant,
   output logic mem_deny,
   output logic mem_write_enable,
   output logic sfr_grant,
   output logic sfr_exception,
   output logic sfr_read_block,
   output logic sfr_write_enable,
   output logic copy_active,
   output mode_type copy_mode,
   output logic [ADDR_W-1:0] seg_ptr
);

   localparam int unsigned IDX_W = $clog2(SEGMENTS);

   typedef seg_entry_type [SEGMENTS-1:0] seg_table_type;

   typedef struct packed {
      seg_table_type seg;
      logic [ADDR_W-1:0] seg_ptr;
      logic copy_active;
      mode_type copy_mode;
      logic mem_grant;
      logic mem_deny;
      logic mem_write_enable;
      logic sfr_grant;
      logic sfr_exception;
      logic sfr_read_block;
      logic sfr_write_enable;
   } state_type;

   state_type st_reg;
   state_type st_next;

   // A segment with no rights at all takes part in no decision
   function automatic logic seg_enabled(input seg_entry_type e);
      seg_enabled = e.rw | e.exec | (|e.hw_rights);
   endfunction

   // Finds the enabled segment covering an address; MSB flags a hit
   function automatic logic [IDX_W:0] seg_lookup(
      input seg_table_type tbl,
      input logic [ADDR_W-1:0] ptr,
      input logic [ADDR_W-1:0] addr);
      logic [IDX_W:0] res;
      res = '0;
      for (int i = SEGMENTS - 1; i >= 0; i--) begin
         if (ptr != SEG_PTR_RESET && seg_enabled(tbl[i]) &&
             addr >= tbl[i].first && addr <= tbl[i].last) begin
            res = {1'b1, IDX_W'(i)};
         end
      end
      seg_lookup = res;
   endfunction

   logic [IDX_W:0] mem_hit;
   logic [IDX_W:0] fetch_hit;
   seg_entry_type mem_seg;
   seg_entry_type fetch_seg;
   mode_type eff_mode;
   logic is_rd;
   logic is_wr;
   logic is_ex;
   logic in_window;
   logic mem_ok;
   logic sfr_ok;
   logic [ADDR_W:0] win_base;
   logic [ADDR_W:0] win_size;
   logic [ADDR_W:0] win_off;

   // Segment matches for the data address and the fetching code
   always_comb begin
      mem_hit = seg_lookup(st_reg.seg, st_reg.seg_ptr, mem_addr);
      fetch_hit = seg_lookup(st_reg.seg, st_reg.seg_ptr, fetch_addr);
      mem_seg = st_reg.seg[mem_hit[IDX_W-1:0]];
      fetch_seg = st_reg.seg[fetch_hit[IDX_W-1:0]];
   end

   // Copy machine accesses during an active copy carry the mode latched at its start
   always_comb begin
      eff_mode = cpu_mode;
      if (mem_master == MASTER_COPY && st_reg.copy_active) begin
         eff_mode = st_reg.copy_mode;
      end
      is_rd = (mem_op == OP_READ);
      is_wr = (mem_op == OP_WRITE);
      is_ex = (mem_op == OP_EXEC);
      win_base = {1'b0, exchange_ram_base_high, exchange_ram_base_low};
      win_size = {1'b0, exchange_ram_size_high, exchange_ram_size_low};
      win_off = {1'b0, mem_addr} - win_base;
      in_window = ({1'b0, mem_addr} >= win_base) && (win_off < win_size);
   end

   // Memory access decision by region and mode
   always_comb begin
      mem_ok = 1'b0;
      case (mem_region)
         REGION_APP_ROM: begin
            case (eff_mode)
               MODE_TEST, MODE_SYSTEM: mem_ok = !is_wr;
               MODE_USER: mem_ok = mem_hit[IDX_W] &&
                  ((is_rd && mem_seg.rw) || (is_ex && mem_seg.exec));
               default: mem_ok = 1'b0;
            endcase
         end
         REGION_APP_EEPROM, REGION_SEC_ROW: begin
            case (eff_mode)
               MODE_TEST, MODE_SYSTEM: mem_ok = 1'b1;
               MODE_BOOT: mem_ok = is_rd && mem_region == REGION_SEC_ROW;
               MODE_FIRMWARE: mem_ok =
                  (is_rd && mem_region == REGION_SEC_ROW) ||
                  (called_from_system && !is_ex);
               MODE_USER: mem_ok = mem_hit[IDX_W] &&
                  (is_ex ? mem_seg.exec : mem_seg.rw);
               default: mem_ok = 1'b0;
            endcase
         end
         REGION_APP_RAM: begin
            case (eff_mode)
               MODE_TEST, MODE_SYSTEM: mem_ok = !is_ex;
               MODE_FIRMWARE: mem_ok = !is_ex && in_window;
               MODE_USER: mem_ok = mem_hit[IDX_W] && mem_seg.rw &&
                  !is_ex;
               default: mem_ok = 1'b0;
            endcase
         end
         REGION_FX_RAM: begin
            mem_ok = !is_ex && (mem_master == MASTER_COPROC ||
               eff_mode == MODE_TEST);
         end
         default: mem_ok = 1'b0;
      endcase
      // Configured read denials override any grant
      if (is_rd && mem_region == REGION_APP_ROM && mem_master == MASTER_CPU
          && fetch_from_eeprom && deny_rom_from_eeprom) begin
         mem_ok = 1'b0;
      end
      if (is_rd && mem_master == MASTER_COPY && mem_region == REGION_APP_ROM
          && copy_deny_rom) begin
         mem_ok = 1'b0;
      end
      if (is_rd && mem_master == MASTER_COPY && copy_deny_eeprom &&
          (mem_region == REGION_APP_EEPROM ||
           mem_region == REGION_SEC_ROW)) begin
         mem_ok = 1'b0;
      end
   end

   // Register access decision by group, mode and special register
   always_comb begin
      sfr_ok = 1'b0;
      case (sfr_group)
         GRP_SEG_CFG: sfr_ok = (cpu_mode == MODE_SYSTEM);
         GRP_SYS_MGMT: sfr_ok = (cpu_mode == MODE_BOOT ||
            cpu_mode == MODE_TEST || cpu_mode == MODE_SYSTEM);
         GRP_FW_CFG: sfr_ok = (cpu_mode == MODE_BOOT ||
            cpu_mode == MODE_TEST || cpu_mode == MODE_SYSTEM ||
            (cpu_mode == MODE_FIRMWARE && !sfr_write));
         GRP_FW_OS: sfr_ok = (cpu_mode == MODE_BOOT ||
            cpu_mode == MODE_TEST || cpu_mode == MODE_FIRMWARE);
         GRP_TEST: sfr_ok = (cpu_mode == MODE_TEST);
         GRP_HW: begin
            case (cpu_mode)
               MODE_BOOT, MODE_TEST, MODE_SYSTEM: sfr_ok = 1'b1;
               MODE_FIRMWARE: sfr_ok = sfr_write ?
                  firewall_ctrl_high[sfr_hw_index] :
                  firewall_ctrl_low[sfr_hw_index];
               MODE_USER: sfr_ok = fetch_hit[IDX_W] &&
                  fetch_seg.hw_rights[sfr_hw_index];
               default: sfr_ok = 1'b0;
            endcase
         end
         GRP_CPU_GEN: sfr_ok = 1'b1;
         GRP_CPU_BANKED: sfr_ok = (cpu_mode == MODE_SYSTEM ||
            cpu_mode == MODE_USER);
         default: sfr_ok = 1'b0;
      endcase
      if (sfr_special == SPC_CSR && !sfr_write &&
          (cpu_mode == MODE_FIRMWARE || cpu_mode == MODE_USER)) begin
         sfr_ok = 1'b1;
      end
      if (sfr_special == SPC_CLKSEL && !sfr_write &&
          cpu_mode == MODE_FIRMWARE) begin
         sfr_ok = 1'b1;
      end
      // Function-based denials apply in every mode
      if ((sfr_special == SPC_PTR_TWO && !sfr_write) ||
          (sfr_special == SPC_RANDOM && sfr_write) ||
          (sfr_special == SPC_KEY && !sfr_write)) begin
         sfr_ok = 1'b0;
      end
   end

   // Next state: table loads, copy machine mode and decision pulses
   always_comb begin
      st_next = st_reg;
      st_next.mem_grant = 1'b0;
      st_next.mem_deny = 1'b0;
      st_next.mem_write_enable = 1'b0;
      st_next.sfr_grant = 1'b0;
      st_next.sfr_exception = 1'b0;
      st_next.sfr_read_block = 1'b0;
      st_next.sfr_write_enable = 1'b0;
      if (seg_ptr_load && cpu_mode == MODE_SYSTEM) begin
         st_next.seg_ptr = seg_ptr_value;
      end
      if (seg_load) begin
         st_next.seg[seg_index] = seg_entry_in;
      end
      if (copy_start && !st_reg.copy_active) begin
         st_next.copy_active = 1'b1;
         st_next.copy_mode = cpu_mode;
      end else if (copy_done) begin
         st_next.copy_active = 1'b0;
      end
      if (mem_req) begin
         st_next.mem_grant = mem_ok;
         st_next.mem_deny = !mem_ok;
         st_next.mem_write_enable = mem_ok && is_wr;
      end
      if (sfr_req) begin
         st_next.sfr_grant = sfr_ok;
         st_next.sfr_exception = !sfr_ok;
         st_next.sfr_read_block = !sfr_ok && !sfr_write;
         st_next.sfr_write_enable = sfr_ok && sfr_write;
      end
   end

   // State register with synchronous restrictive reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.seg_ptr <= SEG_PTR_RESET;
         st_reg.copy_mode <= MODE_BOOT;
      end else begin
         st_reg <= st_next;
      end
   end

   assign mem_grant = st_reg.mem_grant;
   assign mem_deny = st_reg.mem_deny;
   assign mem_write_enable = st_reg.mem_write_enable;
   assign sfr_grant = st_reg.sfr_grant;
   assign sfr_exception = st_reg.sfr_exception;
   assign sfr_read_block = st_reg.sfr_read_block;
   assign sfr_write_enable = st_reg.sfr_write_enable;
   assign copy_active = st_reg.copy_active;
   assign copy_mode = st_reg.copy_mode;
   assign seg_ptr = st_reg.seg_ptr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_copy_begin;
      copy_start && !copy_active;
   endsequence

   sequence s_copy_running;
      copy_active && !copy_done;
   endsequence

   // Mode captured at start stays put while copying
   a_copy_mode_latch: assert property (s_copy_begin |=> copy_mode ==
      $past(cpu_mode)) else $error("copy mode not latched");
   a_copy_mode_hold: assert property (s_copy_running ##1 copy_active
      |-> $stable(copy_mode)) else $error("copy mode changed");
   a_seg_cfg_deny: assert property (sfr_req && sfr_group == GRP_SEG_CFG &&
      cpu_mode != MODE_SYSTEM |=> sfr_exception && !sfr_write_enable)
      else $error("segmentation register reached");
   a_ptr_two_read: assert property (sfr_req && !sfr_write &&
      sfr_special == SPC_PTR_TWO |=> sfr_read_block && !sfr_grant)
      else $error("pointer two was readable");
   a_random_write: assert property (sfr_req && sfr_write &&
      sfr_special == SPC_RANDOM |=> !sfr_write_enable && sfr_exception)
      else $error("random result was written");
   a_key_read: assert property (sfr_req && !sfr_write &&
      sfr_special == SPC_KEY |=> sfr_read_block)
      else $error("key was readable");
   a_banked_deny: assert property (sfr_req &&
      sfr_group == GRP_CPU_BANKED && sfr_special == SPC_NONE &&
      cpu_mode inside {MODE_BOOT, MODE_TEST, MODE_FIRMWARE}
      |=> sfr_exception) else $error("banked access in wrong mode");
   a_cpu_gen_ok: assert property (sfr_req && sfr_group == GRP_CPU_GEN &&
      sfr_special == SPC_NONE |=> sfr_grant && !sfr_exception)
      else $error("general register denied");
   a_mem_one_answer: assert property (mem_req |=> mem_grant != mem_deny)
      else $error("memory answer not exclusive");
   a_no_ptr_user: assert property (mem_req && seg_ptr == SEG_PTR_RESET &&
      cpu_mode == MODE_USER && mem_master == MASTER_CPU &&
      mem_region != REGION_FX_RAM |=> mem_deny)
      else $error("user access without segment table");
   a_copy_rom_deny: assert property (mem_req && mem_master == MASTER_COPY &&
      mem_op == OP_READ && mem_region == REGION_APP_ROM && copy_deny_rom
      |=> mem_deny) else $error("copy machine read ROM");
   a_deny_no_write: assert property (mem_deny |-> !mem_write_enable)
      else $error("denied access enabled write");

   // Every register request gets exactly one verdict
   a_sfr_one_answer: assert property (sfr_req |=>
      sfr_grant != sfr_exception)
      else $error("register answer not exclusive");
   // Firmware may only read the firewall configuration
   a_fw_cfg_ro: assert property (sfr_req && sfr_write &&
      sfr_group == GRP_FW_CFG && sfr_special == SPC_NONE &&
      cpu_mode == MODE_FIRMWARE |=> sfr_exception)
      else $error("firewall configuration written");
   // Code running from EEPROM cannot read ROM when so configured
   a_eeprom_rom_deny: assert property (mem_req && mem_master == MASTER_CPU &&
      mem_op == OP_READ && mem_region == REGION_APP_ROM &&
      fetch_from_eeprom && deny_rom_from_eeprom |=> mem_deny)
      else $error("code from EEPROM read ROM");

endmodule // cpu_mode_access_control

// File: verification/cpu_core_model.sv
// Behavioural CPU core issuing memory and register accesses to the checker
`timescale 1ns/100ps
module cpu_core_model
   import access_control_pkg::*;
(
   input wire logic clk,
   output logic mem_req,
   output master_type mem_master,
   output mem_op_type mem_op,
   output region_type mem_region,
   output logic [ADDR_W-1:0] mem_addr,
   output logic sfr_req,
   output logic sfr_write,
   output sfr_group_type sfr_group,
   output sfr_special_type sfr_special,
   output logic [$clog2(HW_W)-1:0] sfr_hw_index
);

   // Quiet bus at time zero
   initial begin
      mem_req = 1'h0;
      mem_master = MASTER_CPU;
      mem_op = OP_READ;
      mem_region = REGION_OTHER;
      mem_addr = 16'h0000;
      sfr_req = 1'h0;
      sfr_write = 1'h0;
      sfr_group = GRP_CPU_GEN;
      sfr_special = SPC_NONE;
      sfr_hw_index = 3'h0;
   end

   // Memory request held up to its taking edge; answer readable on return
   task automatic mem_acc(input master_type ms, input mem_op_type op,
         input region_type rg, input logic [ADDR_W-1:0] a);
      sfr_req = 1'h0;
      mem_req = 1'h1;
      mem_master = ms;
      mem_op = op;
      mem_region = rg;
      mem_addr = a;
      @(posedge clk) #1;
   endtask

   // Register request, same timing as a memory request
   task automatic sfr_acc(input logic wr, input sfr_group_type g,
         input sfr_special_type sp, input logic [2:0] ix);
      mem_req = 1'h0;
      sfr_req = 1'h1;
      sfr_write = wr;
      sfr_group = g;
      sfr_special = sp;
      sfr_hw_index = ix;
      @(posedge clk) #1;
   endtask

   // Release: lines show inverted values so no stale address survives
   task automatic idle();
      mem_req = 1'h0;
      sfr_req = 1'h0;
      mem_addr = ~mem_addr;
      sfr_hw_index = ~sfr_hw_index;
   endtask

endmodule // cpu_core_model

// File: verification/tb_top.sv
// Self-checking bench for the CPU-mode access checker
`timescale 1ns/100ps
module tb_top
   import access_control_pkg::*;
;
   typedef struct {
      logic s;
      mode_type m;
      logic [1:0] op;
      logic [2:0] g;
      sfr_special_type sp;
      logic [15:0] a;
      logic e;
   } row_type;
   localparam logic T = 1'h1;
   localparam logic F = 1'h0;
   logic clk = 1'h0;
   logic rst_b;
   mode_type cpu_mode, copy_mode;
   logic called_from_system, fetch_from_eeprom, copy_start, copy_done;
   logic deny_rom_from_eeprom, copy_deny_rom, copy_deny_eeprom;
   logic seg_ptr_load, seg_load, mem_req, sfr_req, sfr_write;
   logic [ADDR_W-1:0] fetch_addr, seg_ptr_value, seg_ptr, mem_addr;
   logic [FW_W-1:0] fw_lo, fw_hi, xb_lo, xb_hi, xs_lo, xs_hi;
   logic [5:0] seg_index;
   logic [2:0] sfr_hw_index;
   seg_entry_type seg_entry_in;
   master_type mem_master;
   mem_op_type mem_op;
   region_type mem_region;
   sfr_group_type sfr_group;
   sfr_special_type sfr_special;
   logic mem_grant, mem_deny, mem_write_enable, sfr_grant, sfr_exception;
   logic sfr_read_block, sfr_write_enable, copy_active;
   int n_fail = 0;
   int check_count = 0;
   // Ordinary cases: CPU master, config set up before the loop
   row_type rows [39] = '{
      '{F,MODE_USER,OP_READ,REGION_APP_ROM,SPC_NONE,16'h1800,T},
      '{F,MODE_USER,OP_EXEC,REGION_APP_ROM,SPC_NONE,16'h1800,F},
      '{F,MODE_USER,OP_READ,REGION_APP_ROM,SPC_NONE,16'h2000,F},
      '{F,MODE_USER,OP_WRITE,REGION_APP_EEPROM,SPC_NONE,16'h1000,T},
      '{F,MODE_USER,OP_EXEC,REGION_APP_ROM,SPC_NONE,16'h5000,T},
      '{F,MODE_USER,OP_READ,REGION_APP_EEPROM,SPC_NONE,16'h4000,F},
      '{F,MODE_USER,OP_WRITE,REGION_APP_RAM,SPC_NONE,16'h1FFF,T},
      '{F,MODE_USER,OP_WRITE,REGION_APP_RAM,SPC_NONE,16'h3000,F},
      '{F,MODE_FIRMWARE,OP_WRITE,REGION_APP_RAM,SPC_NONE,16'h02FF,T},
      '{F,MODE_FIRMWARE,OP_READ,REGION_APP_RAM,SPC_NONE,16'h0300,F},
      '{F,MODE_FIRMWARE,OP_READ,REGION_APP_RAM,SPC_NONE,16'h01FF,F},
      '{F,MODE_BOOT,OP_READ,REGION_SEC_ROW,SPC_NONE,16'h0000,T},
      '{F,MODE_FIRMWARE,OP_READ,REGION_SEC_ROW,SPC_NONE,16'h0000,T},
      '{F,MODE_FIRMWARE,OP_WRITE,REGION_APP_EEPROM,SPC_NONE,16'h6000,T},
      '{T,MODE_BOOT,OP_READ,GRP_TEST,SPC_NONE,16'h0000,F},
      '{T,MODE_BOOT,OP_WRITE,GRP_SYS_MGMT,SPC_NONE,16'h0000,T},
      '{T,MODE_BOOT,OP_READ,GRP_SEG_CFG,SPC_NONE,16'h0000,F},
      '{T,MODE_BOOT,OP_READ,GRP_CPU_BANKED,SPC_NONE,16'h0000,F},
      '{T,MODE_TEST,OP_WRITE,GRP_TEST,SPC_NONE,16'h0000,T},
      '{T,MODE_TEST,OP_WRITE,GRP_SEG_CFG,SPC_NONE,16'h0000,F},
      '{T,MODE_FIRMWARE,OP_READ,GRP_FW_CFG,SPC_NONE,16'h0000,T},
      '{T,MODE_FIRMWARE,OP_WRITE,GRP_FW_CFG,SPC_NONE,16'h0000,F},
      '{T,MODE_FIRMWARE,OP_WRITE,GRP_FW_OS,SPC_NONE,16'h0000,T},
      '{T,MODE_FIRMWARE,OP_READ,GRP_HW,SPC_NONE,16'h0000,T},
      '{T,MODE_FIRMWARE,OP_READ,GRP_HW,SPC_NONE,16'h0001,F},
      '{T,MODE_FIRMWARE,OP_WRITE,GRP_HW,SPC_NONE,16'h0001,T},
      '{T,MODE_SYSTEM,OP_WRITE,GRP_SEG_CFG,SPC_NONE,16'h0000,T},
      '{T,MODE_SYSTEM,OP_WRITE,GRP_HW,SPC_NONE,16'h0003,T},
      '{T,MODE_USER,OP_READ,GRP_HW,SPC_NONE,16'h0002,T},
      '{T,MODE_USER,OP_WRITE,GRP_HW,SPC_NONE,16'h0001,F},
      '{T,MODE_USER,OP_READ,GRP_CPU_GEN,SPC_NONE,16'h0000,T},
      '{T,MODE_USER,OP_WRITE,GRP_CPU_BANKED,SPC_NONE,16'h0000,T},
      '{T,MODE_FIRMWARE,OP_READ,GRP_SYS_MGMT,SPC_CSR,16'h0000,T},
      '{T,MODE_USER,OP_READ,GRP_SYS_MGMT,SPC_CSR,16'h0000,T},
      '{T,MODE_FIRMWARE,OP_READ,GRP_HW,SPC_CLKSEL,16'h0004,T},
      '{T,MODE_SYSTEM,OP_READ,GRP_SYS_MGMT,SPC_PTR_TWO,16'h0000,F},
      '{T,MODE_SYSTEM,OP_WRITE,GRP_HW,SPC_RANDOM,16'h0000,F},
      '{T,MODE_SYSTEM,OP_READ,GRP_HW,SPC_KEY,16'h0000,F},
      '{T,MODE_SYSTEM,OP_WRITE,GRP_HW,SPC_KEY,16'h0000,T}
   };

   always #2 clk = ~clk;

   cpu_core_model u_cpu (.clk(clk), .mem_req(mem_req),
      .mem_master(mem_master), .mem_op(mem_op), .mem_region(mem_region),
      .mem_addr(mem_addr), .sfr_req(sfr_req), .sfr_write(sfr_write),
      .sfr_group(sfr_group), .sfr_special(sfr_special),
      .sfr_hw_index(sfr_hw_index));

   cpu_mode_access_control u_dut (.clk(clk), .rst_b(rst_b),
      .cpu_mode(cpu_mode), .called_from_system(called_from_system),
      .fetch_addr(fetch_addr), .fetch_from_eeprom(fetch_from_eeprom),
      .mem_req(mem_req), .mem_master(mem_master), .mem_op(mem_op),
      .mem_region(mem_region), .mem_addr(mem_addr), .sfr_req(sfr_req),
      .sfr_write(sfr_write), .sfr_group(sfr_group),
      .sfr_special(sfr_special), .sfr_hw_index(sfr_hw_index),
      .firewall_ctrl_low(fw_lo), .firewall_ctrl_high(fw_hi),
      .exchange_ram_base_low(xb_lo), .exchange_ram_base_high(xb_hi),
      .exchange_ram_size_low(xs_lo), .exchange_ram_size_high(xs_hi),
      .deny_rom_from_eeprom(deny_rom_from_eeprom),
      .copy_deny_rom(copy_deny_rom), .copy_deny_eeprom(copy_deny_eeprom),
      .copy_start(copy_start), .copy_done(copy_done),
      .seg_ptr_load(seg_ptr_load), .seg_ptr_value(seg_ptr_value),
      .seg_load(seg_load), .seg_index(seg_index),
      .seg_entry_in(seg_entry_in), .mem_grant(mem_grant),
      .mem_deny(mem_deny), .mem_write_enable(mem_write_enable),
      .sfr_grant(sfr_grant), .sfr_exception(sfr_exception),
      .sfr_read_block(sfr_read_block), .sfr_write_enable(sfr_write_enable),
      .copy_active(copy_active), .copy_mode(copy_mode), .seg_ptr(seg_ptr));

   // Comparison, counting and reporting
   task automatic chk(input string nm, input logic [15:0] exp, got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic do_mem(input master_type ms, input mem_op_type op,
         input region_type rg, input logic [15:0] a, input logic e);
      u_cpu.mem_acc(ms, op, rg, a);
      chk("mem_grant", e, mem_grant);
      chk("mem_deny", !e, mem_deny);
      chk("mem_write_enable", e && op == OP_WRITE, mem_write_enable);
   endtask

   task automatic do_sfr(input logic wr, input logic [2:0] g,
         input sfr_special_type sp, input logic [2:0] ix, input logic e);
      u_cpu.sfr_acc(wr, sfr_group_type'(g), sp, ix);
      chk("sfr_grant", e, sfr_grant);
      chk("sfr_exception", !e, sfr_exception);
      chk("sfr_read_block", !e && !wr, sfr_read_block);
      chk("sfr_write_enable", e && wr, sfr_write_enable);
   endtask

   // Segment table and pointer loads, one-cycle pulses
   task automatic seg_wr(input logic [5:0] ix, input seg_entry_type en);
      seg_index = ix;
      seg_entry_in = en;
      seg_load = 1'h1;
      @(posedge clk) #1;
      seg_load = 1'h0;
      @(posedge clk) #1;
   endtask

   task automatic ptr_wr(input logic [15:0] v);
      seg_ptr_value = v;
      seg_ptr_load = 1'h1;
      @(posedge clk) #1;
      seg_ptr_load = 1'h0;
      @(posedge clk) #1;
   endtask

   // Watchdog, far beyond the 74 cycles the tests take
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      complete_run();
   end

   // Main sequence
   initial begin
      rst_b = 1'h0;
      cpu_mode = MODE_USER;
      called_from_system = 1'h1;
      fetch_from_eeprom = 1'h0;
      fetch_addr = 16'h1000;
      {copy_start, copy_done, seg_ptr_load, seg_load} = 4'h0;
      {deny_rom_from_eeprom, copy_deny_rom, copy_deny_eeprom} = 3'h0;
      seg_ptr_value = 16'h0000;
      seg_index = 6'h00;
      seg_entry_in = '0;
      fw_lo = 8'h01;
      fw_hi = 8'h02;
      {xb_hi, xb_lo} = 16'h0200;
      {xs_hi, xs_lo} = 16'h0100;
      repeat (6) @(posedge clk);
      #1;
      chk("seg_ptr", SEG_PTR_RESET, seg_ptr);
      chk("copy_active", 1'h0, copy_active);
      rst_b = 1'h1;
      do_mem(MASTER_CPU, OP_EXEC, REGION_APP_ROM, 16'h1800, F);
      u_cpu.idle();
      cpu_mode = MODE_SYSTEM;
      seg_wr(6'h00, '{16'h1000, 16'h1FFF, T, F, 8'h05});
      seg_wr(6'h01, '{16'h4000, 16'h4FFF, F, F, 8'h00});
      seg_wr(6'h3F, '{16'h5000, 16'h5FFF, T, T, 8'h00});
      ptr_wr(16'h0800);
      chk("seg_ptr", 16'h0800, seg_ptr);
      cpu_mode = MODE_USER;
      ptr_wr(16'h0900);
      chk("seg_ptr", 16'h0800, seg_ptr);
      foreach (rows[i]) begin
         cpu_mode = rows[i].m;
         if (rows[i].s)
            do_sfr(rows[i].op == OP_WRITE, rows[i].g, rows[i].sp,
               rows[i].a[2:0], rows[i].e);
         else
            do_mem(MASTER_CPU, mem_op_type'(rows[i].op),
               region_type'(rows[i].g), rows[i].a, rows[i].e);
      end
      // Awkward cases: call origin, coprocessor RAM, denial options, copy
      cpu_mode = MODE_FIRMWARE;
      called_from_system = 1'h0;
      do_mem(MASTER_CPU, OP_WRITE, REGION_APP_EEPROM, 16'h6000, F);
      called_from_system = 1'h1;
      cpu_mode = MODE_USER;
      do_mem(MASTER_COPROC, OP_WRITE, REGION_FX_RAM, 16'h0000, T);
      do_mem(MASTER_COPROC, OP_READ, REGION_FX_RAM, 16'h0010, T);
      cpu_mode = MODE_SYSTEM;
      fetch_from_eeprom = 1'h1;
      for (int k = 0; k < 3; k++) begin
         {copy_deny_eeprom, copy_deny_rom, deny_rom_from_eeprom} = 3'h1 << k;
         do_mem(MASTER_CPU, OP_READ, REGION_APP_ROM, 16'h1800, k != 0);
         do_mem(MASTER_COPY, OP_READ, REGION_APP_ROM, 16'h1800, k != 1);
         do_mem(MASTER_COPY, OP_READ, REGION_APP_EEPROM, 16'h1800, k != 2);
      end
      {deny_rom_from_eeprom, copy_deny_rom, copy_deny_eeprom} = 3'h0;
      fetch_from_eeprom = 1'h0;
      u_cpu.idle();
      copy_start = 1'h1;
      @(posedge clk) #1;
      copy_start = 1'h0;
      cpu_mode = MODE_USER;
      chk("copy_active", 1'h1, copy_active);
      do_mem(MASTER_COPY, OP_READ, REGION_APP_EEPROM, 16'h6000, T);
      do_mem(MASTER_CPU, OP_READ, REGION_APP_EEPROM, 16'h6000, F);
      copy_start = 1'h1;
      @(posedge clk) #1;
      copy_start = 1'h0;
      copy_done = 1'h1;
      chk("copy_mode", MODE_SYSTEM, copy_mode);
      @(posedge clk) #1;
      copy_done = 1'h0;
      chk("copy_active", 1'h0, copy_active);
      do_mem(MASTER_COPY, OP_READ, REGION_APP_EEPROM, 16'h6000, F);
      complete_run();
   end

endmodule // tb_top
